// File: design/monitor_config_alert.sv
// Top of the monitor configuration, offset and alert mask register slice
module monitor_config_alert
  import monitor_pkg::*;
#(
  parameter int unsigned AVG_COUNT = AVG_SAMPLES
)(
  input wire logic clk, // System clock, 10 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [ADDR_W-1:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [DATA_W-1:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [DATA_W-1:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall the master
  output logic irq, // Level interrupt
  input wire logic [7:0] remote_two_raw, // Raw remote-two reading
  input wire logic remote_two_raw_valid, // Raw reading strobe
  output logic [7:0] remote_two_temp, // Offset-corrected reading
  output logic [NUM_FANS-1:0] fan_two_wire_select, // Per-fan 2-wire sensing
  output logic attenuator_bypass, // Input dividers disconnected
  input wire logic [2:0] single_channel_sel, // Top bits of the limit register
  input wire logic ext_start_enable, // Test bit for external start
  input wire logic ext_start_in, // External start on a fan sense input
  input wire logic adc_done, // Converter finished a sample
  output logic adc_start, // Start one sample
  output monitor_pkg::channel_e adc_channel, // Channel to convert
  output logic result_valid, // Averaged result ready
  input wire logic [NUM_MON_CH-1:0] limit_event, // Out-of-limit per channel
  input wire logic [NUM_FAULTS-1:0] fault_event, // Second-group faults
  input wire logic [7:0] alert_mask_two, // Second mask register
  input wire logic alert_enable, // Alert-enable bit of later config
  input wire logic fan_two_pwm, // Fan two drive level
  output logic shared_pin_o, // Shared pin output value
  output logic shared_pin_oe_n // Shared pin enable, low drives
);
  import monitor_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [DATA_W-1:0] rdata;
    logic [REG_W-1:0] offset;
    logic [REG_W-1:0] cfg;
    logic [REG_W-1:0] mask;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_msk;
    logic [REG_W-1:0] temp;
    logic alert_prev;
    logic pin_o;
    logic pin_oe_n;
  } top_s;

  top_s q, d;
  logic req;
  logic wr_go;
  logic [IDX_W-1:0] idx;
  logic [NUM_MON_CH-1:0] limit_clear;
  logic [NUM_FAULTS-1:0] fault_clear;
  logic [NUM_MON_CH-1:0] limit_status;
  logic [NUM_FAULTS-1:0] fault_status;
  logic alert;
  logic scan_done;

  function automatic logic hit(input logic [IDX_W-1:0] a, input logic [IDX_W-1:0] r);
    hit = (a == r);
  endfunction

  function automatic logic [DATA_W-1:0] widen(input logic [REG_W-1:0] v);
    widen = {{(DATA_W-REG_W){1'b0}}, v};
  endfunction

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  single_channel_mode_sequencer #(.AVG_COUNT(AVG_COUNT)) u_seq (
    .clk(clk),
    .rst(rst),
    .single_channel_mode(q.cfg[CFG_SINGLE]),
    .averaging_disable(q.cfg[CFG_AVG_DIS]),
    .single_channel_sel(single_channel_sel),
    .ext_start_enable(ext_start_enable),
    .ext_start_in(ext_start_in),
    .adc_done(adc_done),
    .adc_start(adc_start),
    .adc_channel(adc_channel),
    .result_valid(result_valid),
    .scan_done(scan_done)
  );

  alert_mask u_alert (
    .clk(clk),
    .rst(rst),
    .mask_one(q.mask),
    .mask_two(alert_mask_two),
    .limit_event(limit_event),
    .fault_event(fault_event),
    .limit_clear(limit_clear),
    .fault_clear(fault_clear),
    .limit_status(limit_status),
    .fault_status(fault_status),
    .alert(alert)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // One wait state: the request is seen, then answered on the next edge
  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && !q.ack;
  assign wr_go = avs_write && q.ack && avs_byteenable[0];
  assign idx = avs_address[ADDR_W-1:2];
  // Clear strobes fire only in the acknowledge cycle, so a held write clears once
  assign limit_clear = (wr_go && hit(idx, IDX_LIMIT_STATUS))
    ? avs_writedata[NUM_MON_CH-1:0] : '0;
  assign fault_clear = (wr_go && hit(idx, IDX_FAULT_STATUS))
    ? avs_writedata[NUM_FAULTS-1:0] : '0;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.ack = req && !q.ack;
    if (avs_read && !q.ack)
    begin
      // Unmapped indices read as zero
      if (hit(idx, IDX_REMOTE_TWO_OFFSET))
        d.rdata = widen(q.offset);
      else if (hit(idx, IDX_CONFIG_TWO))
        d.rdata = widen(q.cfg);
      else if (hit(idx, IDX_ALERT_MASK_ONE))
        d.rdata = widen(q.mask);
      else if (hit(idx, IDX_LIMIT_STATUS))
        d.rdata = widen({1'b0, limit_status});
      else if (hit(idx, IDX_FAULT_STATUS))
        d.rdata = widen(fault_status);
      else if (hit(idx, IDX_IRQ_STATUS))
        d.rdata = widen({{(REG_W-IRQ_W){1'b0}}, q.irq_st});
      else if (hit(idx, IDX_IRQ_MASK))
        d.rdata = widen({{(REG_W-IRQ_W){1'b0}}, q.irq_msk});
      else if (hit(idx, IDX_REMOTE_TWO_RESULT))
        d.rdata = widen(q.temp);
      else
        d.rdata = '0;
    end
    if (wr_go)
    begin
      // Every field sits in byte lane 0; the upper lanes carry nothing
      if (hit(idx, IDX_REMOTE_TWO_OFFSET))
      begin
        d.offset = avs_writedata[REG_W-1:0];
      end
      if (hit(idx, IDX_CONFIG_TWO))
      begin
        d.cfg = avs_writedata[REG_W-1:0];
      end
      if (hit(idx, IDX_ALERT_MASK_ONE))
      begin
        d.mask = avs_writedata[REG_W-1:0];
      end
      if (hit(idx, IDX_IRQ_MASK))
      begin
        d.irq_msk = avs_writedata[IRQ_W-1:0];
      end
      if (hit(idx, IDX_IRQ_STATUS))
      begin
        d.irq_st = q.irq_st & ~avs_writedata[IRQ_W-1:0];
      end
    end
    // Events set after the clear so a same-cycle event is kept
    if (alert && !q.alert_prev)
    begin
      d.irq_st[IRQ_ALERT] = 1'b1;
    end
    if (scan_done)
    begin
      d.irq_st[IRQ_SCAN_DONE] = 1'b1;
    end
    d.alert_prev = alert;
    // Two's complement offset; the sum wraps rather than saturates
    if (remote_two_raw_valid)
    begin
      d.temp = REG_W'(remote_two_raw + q.offset);
    end
    // Released rather than driven high, so other open-drain sources can share the line
    // SMBALERT is open drain and active low; otherwise the pin is a push-pull drive
    if (alert_enable)
    begin
      d.pin_o = 1'b0;
      d.pin_oe_n = !alert;
    end
    else
    begin
      d.pin_o = fan_two_pwm;
      d.pin_oe_n = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '{
        ack: 1'b0,
        rdata: '0,
        offset: REG_RESET,
        cfg: REG_RESET,
        mask: REG_RESET,
        irq_st: '0,
        irq_msk: '0,
        temp: REG_RESET,
        alert_prev: 1'b0,
        pin_o: 1'b0,
        pin_oe_n: 1'b1
      };
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata = q.rdata;
  assign irq = |(q.irq_st & q.irq_msk);
  assign remote_two_temp = q.temp;
  assign fan_two_wire_select = q.cfg[NUM_FANS-1:0];
  assign attenuator_bypass = q.cfg[CFG_ATTENUATOR_BYPASS];
  assign shared_pin_o = q.pin_o;
  assign shared_pin_oe_n = q.pin_oe_n;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_offset_applied: assert property (@(posedge clk) disable iff (rst)
    remote_two_raw_valid |=> remote_two_temp == 8'($past(remote_two_raw) + $past(q.offset)))
    else $error("remote-two reading not corrected by the offset");
  a_fan_select: assert property (@(posedge clk) disable iff (rst)
    wr_go && hit(idx, IDX_CONFIG_TWO)
    |=> fan_two_wire_select == $past(avs_writedata[NUM_FANS-1:0]))
    else $error("fan sensing select did not follow the configuration write");
  a_attenuator_bypass_follow: assert property (@(posedge clk) disable iff (rst)
    wr_go && hit(idx, IDX_CONFIG_TWO) |=> attenuator_bypass == $past(avs_writedata[CFG_ATTENUATOR_BYPASS]))
    else $error("attenuator bypass did not follow the configuration write");
  a_rsvd_bit_rw: assert property (@(posedge clk) disable iff (rst)
    avs_read && q.ack && hit(idx, IDX_CONFIG_TWO) |-> avs_readdata[REG_W-1:0] == q.cfg)
    else $error("configuration readback lost the reserved bit");
  a_status_kept: assert property (@(posedge clk) disable iff (rst)
    limit_event[0] |=> limit_status[0])
    else $error("masked out-of-limit condition not recorded");
  a_pin_mux: assert property (@(posedge clk) disable iff (rst)
    !alert_enable ##1 !alert_enable |-> !shared_pin_oe_n && shared_pin_o == $past(fan_two_pwm))
    else $error("shared pin not driven as fan two output");
  a_alert_drive: assert property (@(posedge clk) disable iff (rst)
    alert_enable && alert |=> !shared_pin_oe_n && !shared_pin_o || !$past(alert_enable))
    else $error("alert not driven low on the shared pin");
  a_pin_released: assert property (@(posedge clk) disable iff (rst)
    alert_enable && !alert
    |=> shared_pin_oe_n)
    else $error("shared pin pulled low with no alert pending");
  a_fault_kept: assert property (@(posedge clk) disable iff (rst)
    fault_event != '0
    |=> (fault_status & $past(fault_event)) == $past(fault_event))
    else $error("fault condition not recorded");
  a_mask_write: assert property (@(posedge clk) disable iff (rst)
    wr_go && hit(idx, IDX_ALERT_MASK_ONE)
    |=> q.mask == $past(avs_writedata[REG_W-1:0]))
    else $error("first mask register did not take the written value");
  a_offset_kept: assert property (@(posedge clk) disable iff (rst)
    !(wr_go && hit(idx, IDX_REMOTE_TWO_OFFSET))
    |=> q.offset == $past(q.offset))
    else $error("offset changed without a write");
  a_cfg_kept: assert property (@(posedge clk) disable iff (rst)
    !(wr_go && hit(idx, IDX_CONFIG_TWO))
    |=> q.cfg == $past(q.cfg))
    else $error("configuration changed without a write");
  // Bus answers after exactly one wait state; a longer stall would hang the master
  a_bus_one_wait: assert property (@(posedge clk) disable iff (rst)
    avs_waitrequest
    |=> !avs_waitrequest)
    else $error("bus request stalled for more than one wait state");
endmodule // monitor_config_alert

// File: design/monitor_pkg.sv
// Shared constants and types for the monitor configuration and alert slice
package monitor_pkg;
  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;
  localparam int unsigned IDX_W = 8;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_REMOTE_TWO_OFFSET = 8'h72;
  localparam logic [IDX_W-1:0] IDX_CONFIG_TWO = 8'h73;
  localparam logic [IDX_W-1:0] IDX_ALERT_MASK_ONE = 8'h74;
  localparam logic [IDX_W-1:0] IDX_LIMIT_STATUS = 8'h80;
  localparam logic [IDX_W-1:0] IDX_FAULT_STATUS = 8'h81;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 8'h82;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'h83;
  localparam logic [IDX_W-1:0] IDX_REMOTE_TWO_RESULT = 8'h84;
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned NUM_FANS = 4;
  localparam int unsigned CFG_AVG_DIS = 4;
  localparam int unsigned CFG_ATTENUATOR_BYPASS = 5;
  localparam int unsigned CFG_SINGLE = 6;
  localparam int unsigned NUM_MON_CH = 7;
  localparam int unsigned MASK_SECOND_EN = 7;
  localparam int unsigned NUM_FAULTS = 8;
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_ALERT = 0;
  localparam int unsigned IRQ_SCAN_DONE = 1;
  localparam int unsigned AVG_SAMPLES = 16;
  // ----------------------------------------------------------------
  // Conversion channel codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CH_2V5 = 3'h0,
    CH_CORE = 3'h1,
    CH_SUPPLY = 3'h2,
    CH_5V = 3'h3,
    CH_12V = 3'h4,
    CH_REMOTE_ONE = 3'h5,
    CH_LOCAL = 3'h6,
    CH_REMOTE_TWO = 3'h7
  } channel_e;
endpackage

// File: design/single_channel_mode_sequencer.sv
// Conversion sequencer: round-robin scan, single-channel mode and averaging
module single_channel_mode_sequencer
  import monitor_pkg::*;
#(
  parameter int unsigned AVG_COUNT = AVG_SAMPLES
)(
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic single_channel_mode, // Convert one channel only
  input wire logic averaging_disable, // One sample per result
  input wire logic [2:0] single_channel_sel, // Channel code in single mode
  input wire logic ext_start_enable, // External start in single mode
  input wire logic ext_start_in, // External start clock level
  input wire logic adc_done, // Converter finished a sample
  output logic adc_start, // Start one sample, one-cycle pulse
  output monitor_pkg::channel_e adc_channel, // Channel being converted
  output logic result_valid, // Result complete, one-cycle pulse
  output logic scan_done // Full scan complete, one-cycle pulse
);
  import monitor_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_START, S_WAIT} seq_state_e;
  typedef struct packed {
    seq_state_e st;
    channel_e ch;
    logic [7:0] cnt;
    logic ext_prev;
    logic start;
    logic valid;
    logic done;
  } seq_s;

  localparam logic [7:0] LAST_SAMPLE = 8'(AVG_COUNT - 1);
  seq_s q, d;

  always_comb
  begin
    d = q;
    d.start = 1'b0;
    d.valid = 1'b0;
    d.done = 1'b0;
    d.ext_prev = ext_start_in;
    case (q.st)
      S_IDLE:
      begin
        if (single_channel_mode)
        begin
          d.ch = channel_e'(single_channel_sel);
          if (!ext_start_enable || (ext_start_in && !q.ext_prev))
          begin
            d.st = S_START;
          end
        end
        else
        begin
          d.st = S_START;
        end
      end
      S_START:
      begin
        d.start = 1'b1;
        d.st = S_WAIT;
      end
      S_WAIT:
      begin
        if (adc_done)
        begin
          d.st = S_IDLE;
          if (averaging_disable || q.cnt == LAST_SAMPLE)
          begin
            d.cnt = 8'h00;
            d.valid = 1'b1;
            if (!single_channel_mode)
            begin
              d.ch = channel_e'(q.ch + 3'h1);
              d.done = (q.ch == CH_REMOTE_TWO);
            end
          end
          else
          begin
            d.cnt = q.cnt + 8'h01;
          end
        end
      end
      default: d.st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '{st: S_IDLE, ch: CH_2V5, cnt: 8'h00, default: 1'b0};
    end
    else
    begin
      q <= d;
    end
  end

  assign adc_start = q.start;
  assign adc_channel = q.ch;
  assign result_valid = q.valid;
  assign scan_done = q.done;

  a_single_holds_channel: assert property (@(posedge clk) disable iff (rst)
    q.st == S_START && $past(single_channel_mode)
    |-> q.ch == channel_e'($past(single_channel_sel)))
    else $error("single mode converted a channel other than the selected one");
  a_avg_off_one: assert property (@(posedge clk) disable iff (rst)
    averaging_disable && q.st == S_WAIT && adc_done
    |=> result_valid)
    else $error("result withheld although averaging is disabled");
  a_ext_start_wait: assert property (@(posedge clk) disable iff (rst)
    single_channel_mode && ext_start_enable && q.st == S_IDLE
      && !(ext_start_in && !q.ext_prev)
    |=> q.st == S_IDLE)
    else $error("single conversion started without an external edge");
endmodule // single_channel_mode_sequencer

// File: design/alert_mask.sv
// Out-of-limit and fault status recording with alert masking
module alert_mask
  import monitor_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [7:0] mask_one, // First mask register
  input wire logic [7:0] mask_two, // Second mask register
  input wire logic [NUM_MON_CH-1:0] limit_event, // Channel out of limit
  input wire logic [NUM_FAULTS-1:0] fault_event, // Second-group faults
  input wire logic [NUM_MON_CH-1:0] limit_clear, // Write-one-to-clear
  input wire logic [NUM_FAULTS-1:0] fault_clear, // Write-one-to-clear
  output logic [NUM_MON_CH-1:0] limit_status, // Sticky limit status
  output logic [NUM_FAULTS-1:0] fault_status, // Sticky fault status
  output logic alert // Unmasked condition pending
);
  import monitor_pkg::*;

  typedef struct packed {
    logic [NUM_MON_CH-1:0] lim;
    logic [NUM_FAULTS-1:0] flt;
    logic al;
  } am_s;

  am_s q, d;
  logic [NUM_FAULTS-1:0] eff_mask_two;

  always_comb
  begin
    // Second mask only counts while the enable bit is set
    eff_mask_two = mask_one[MASK_SECOND_EN] ? mask_two : '0;
    // Status records regardless of masks; a new event beats a clear
    d.lim = (q.lim & ~limit_clear) | limit_event;
    d.flt = (q.flt & ~fault_clear) | fault_event;
    d.al = |(d.lim & ~mask_one[NUM_MON_CH-1:0]) | |(d.flt & ~eff_mask_two);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign limit_status = q.lim;
  assign fault_status = q.flt;
  assign alert = q.al;

  a_mask_blocks_alert: assert property (@(posedge clk) disable iff (rst)
    (q.lim & ~$past(mask_one[NUM_MON_CH-1:0])) == '0 && q.flt == '0 |-> !alert)
    else $error("alert raised while every limit bit was masked");
  a_second_mask_gate: assert property (@(posedge clk) disable iff (rst)
    $past(!mask_one[MASK_SECOND_EN]) && $past(d.flt) != '0 |-> alert)
    else $error("second mask took effect while its enable was clear");
endmodule // alert_mask

// File: sim/adc_model.sv
// Converter stand-in that answers a start pulse with a done pulse unless another start comes first
module adc_model #(
  parameter int unsigned LATENCY = 3
)(
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic adc_start, // Start one sample
  output logic adc_done // Sample finished, one-cycle pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned count_q;
  // A start arriving mid-sample restarts the count, as a real converter would
  always_ff @(posedge clk)
  begin
    adc_done <= 1'b0;
    if (rst)
      count_q <= 0;
    else if (adc_start)
      count_q <= LATENCY;
    else if (count_q != 0)
    begin
      count_q <= count_q - 1;
      adc_done <= (count_q == 1);
    end
  end
endmodule // adc_model

// File: sim/tb_top.sv
// Self-checking bench for the monitor configuration and alert slice
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin miscompares++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, gt); end end
module tb_top import monitor_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest, irq, attenuator_bypass, adc_start, adc_done, result_valid;
  logic [7:0] remote_two_raw = 8'h00;
  logic remote_two_raw_valid = 1'b0;
  logic [7:0] remote_two_temp;
  logic [NUM_FANS-1:0] fan_two_wire_select;
  logic [2:0] single_channel_sel = 3'h0;
  logic ext_start_enable = 1'b0;
  logic ext_start_in = 1'b0;
  channel_e adc_channel;
  logic [NUM_MON_CH-1:0] limit_event = '0;
  logic [NUM_FAULTS-1:0] fault_event = '0;
  logic [7:0] alert_mask_two = 8'h00;
  logic alert_enable = 1'b0;
  logic fan_two_pwm = 1'b0;
  logic shared_pin_o, shared_pin_oe_n;
  logic [7:0] rd;
  int n;
  int miscompares = 0;
  int total_checks = 0;

  monitor_config_alert #(.AVG_COUNT(2)) dut (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .remote_two_raw(remote_two_raw),
    .remote_two_raw_valid(remote_two_raw_valid), .remote_two_temp(remote_two_temp),
    .fan_two_wire_select(fan_two_wire_select), .attenuator_bypass(attenuator_bypass),
    .single_channel_sel(single_channel_sel), .ext_start_enable(ext_start_enable),
    .ext_start_in(ext_start_in), .adc_done(adc_done), .adc_start(adc_start),
    .adc_channel(adc_channel), .result_valid(result_valid), .limit_event(limit_event),
    .fault_event(fault_event), .alert_mask_two(alert_mask_two), .alert_enable(alert_enable),
    .fan_two_pwm(fan_two_pwm), .shared_pin_o(shared_pin_o), .shared_pin_oe_n(shared_pin_oe_n));
  adc_model #(.LATENCY(3)) adc (.clk(clk), .rst(rst), .adc_start(adc_start), .adc_done(adc_done));

  initial
  begin
    forever #50 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Bus and timing helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                     input logic [3:0] be, output logic [7:0] rdata);
    int k;
    k = 0;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, wd};
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= ~w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && k < 20)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= 20)
      miscompares++;
    rdata = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [7:0] d;
    bus(1'b1, idx, v, 4'hF, d);
  endtask
  task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] ex);
    logic [7:0] d;
    bus(1'b0, idx, 8'h00, 4'hF, d);
    `CHK(nm, ex, d)
  endtask
  // Pulses events, then leaves time for status, alert and pin stages to settle
  task automatic pulse(input logic [6:0] l, input logic [7:0] f);
    limit_event <= l;
    fault_event <= f;
    @(posedge clk);
    limit_event <= '0;
    fault_event <= '0;
    cyc(4);
  endtask
  task automatic clear_all();
    wr(IDX_LIMIT_STATUS, 8'h7F);
    wr(IDX_FAULT_STATUS, 8'hFF);
    wr(IDX_IRQ_STATUS, 8'h03);
    cyc(3);
  endtask
  // Counts converter starts between two consecutive results
  task automatic count_starts(output int c);
    int k;
    c = 0;
    k = 0;
    do begin @(posedge clk); k++; end while (result_valid !== 1'b1 && k < 200);
    do begin @(posedge clk); k++; c += (adc_start === 1'b1); end
    while (result_valid !== 1'b1 && k < 400);
  endtask
  task automatic starts_in(input int k, output int c);
    c = 0;
    repeat (k)
    begin
      @(posedge clk);
      c += (adc_start === 1'b1);
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rchk("offset reset", IDX_REMOTE_TWO_OFFSET, REG_RESET);
    rchk("config reset", IDX_CONFIG_TWO, REG_RESET);
    rchk("mask reset", IDX_ALERT_MASK_ONE, REG_RESET);
    `CHK("pin fan at reset", 1'b0, shared_pin_oe_n)
    `CHK("pin fan level", 1'b0, shared_pin_o)
    wr(8'h10, 8'h5A);
    rchk("unmapped", 8'h10, 8'h00);
    wr(IDX_REMOTE_TWO_OFFSET, 8'hF0);
    bus(1'b1, IDX_REMOTE_TWO_OFFSET, 8'h33, 4'h0, rd);
    rchk("lane off ignored", IDX_REMOTE_TWO_OFFSET, 8'hF0);
    remote_two_raw <= 8'h25;
    remote_two_raw_valid <= 1'b1;
    @(posedge clk);
    remote_two_raw_valid <= 1'b0;
    cyc(2);
    `CHK("corrected temp", 8'h15, remote_two_temp)
    rchk("corrected reg", IDX_REMOTE_TWO_RESULT, 8'h15);
    wr(IDX_CONFIG_TWO, 8'hA5);
    rchk("config back", IDX_CONFIG_TWO, 8'hA5);
    `CHK("fan sense", 4'h5, fan_two_wire_select)
    `CHK("atten on", 1'b1, attenuator_bypass)
    wr(IDX_CONFIG_TWO, 8'h0A);
    cyc(2);
    `CHK("fan sense b", 4'hA, fan_two_wire_select)
    `CHK("atten off", 1'b0, attenuator_bypass)
  endtask
  task automatic t_alert();
    fan_two_pwm <= 1'b1;
    cyc(3);
    `CHK("pin fan", 1'b1, shared_pin_o)
    `CHK("pin driven", 1'b0, shared_pin_oe_n)
    alert_enable <= 1'b1;
    wr(IDX_IRQ_MASK, 8'h01);
    clear_all();
    for (int ch = 0; ch < 7; ch++)
    begin
      wr(IDX_ALERT_MASK_ONE, 8'(1 << ch));
      pulse(7'(1 << ch), 8'h00);
      `CHK("masked pin", 1'b1, shared_pin_oe_n)
      rchk("status kept", IDX_LIMIT_STATUS, 8'(1 << ch));
      wr(IDX_LIMIT_STATUS, 8'h7F);
      wr(IDX_ALERT_MASK_ONE, 8'h00);
      pulse(7'(1 << ch), 8'h00);
      `CHK("alert pin", 1'b0, shared_pin_oe_n)
      `CHK("alert pin low", 1'b0, shared_pin_o)
      `CHK("irq raised", 1'b1, irq)
      clear_all();
      `CHK("pin cleared", 1'b1, shared_pin_oe_n)
      `CHK("irq cleared", 1'b0, irq)
    end
    pulse(7'h01, 8'h00);
    wr(IDX_IRQ_MASK, 8'h00);
    cyc(2);
    `CHK("irq masked", 1'b0, irq)
    clear_all();
    alert_mask_two <= 8'hFF;
    pulse(7'h00, 8'h08);
    `CHK("second mask off", 1'b0, shared_pin_oe_n)
    clear_all();
    wr(IDX_ALERT_MASK_ONE, 8'h80);
    pulse(7'h00, 8'h08);
    `CHK("second mask on", 1'b1, shared_pin_oe_n)
    rchk("fault kept", IDX_FAULT_STATUS, 8'h08);
    clear_all();
  endtask
  task automatic t_seq();
    // Scan mode is still running: two full scans fit easily in this wait
    cyc(250);
    rchk("scan done", IDX_IRQ_STATUS, 8'h02);
    single_channel_sel <= 3'h3;
    wr(IDX_CONFIG_TWO, 8'h40);
    count_starts(n);
    count_starts(n);
    `CHK("averaged", 2, n)
    wr(IDX_CONFIG_TWO, 8'h50);
    for (int c = 0; c < 8; c++)
    begin
      single_channel_sel <= 3'(c);
      count_starts(n);
      count_starts(n);
      `CHK("single channel", 3'(c), adc_channel)
      `CHK("one sample", 1, n)
    end
    ext_start_enable <= 1'b1;
    cyc(20);
    starts_in(20, n);
    `CHK("waits for ext", 0, n)
    ext_start_in <= 1'b1;
    starts_in(10, n);
    `CHK("ext start", 1, n)
    ext_start_in <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_alert();
    t_seq();
    final_report();
  end
  initial
  begin
    #1000000;
    miscompares++;
    final_report();
  end
endmodule // tb_top
